// ===== common/irq_bank_params.svh
// offsets, field layouts, reset values and edge types of the raw status bank
`ifndef IRQ_BANK_PARAMS_SVH
`define IRQ_BANK_PARAMS_SVH

// register indices, byte address is four times the index
`define IDX_RAW_DSP      14'h0d20
`define IDX_RAW_CLOCK    14'h0d21
`define IDX_RAW_CONTROL  14'h0d22
`define IDX_RAW_BOOT     14'h0d23
`define IDX_RAW_OVER_A   14'h0d24
`define IDX_RAW_OVER_B   14'h0d25
`define IDX_RAW_UNDER    14'h0d26
`define IDX_RAW_SHORT    14'h0d28
`define IDX_PIN_SUMMARY  14'h0d40
`define IDX_RAW_AOD      14'h0d55
`define IDX_CLK_CTRL     14'h0d60
`define IDX_FLAG_ONE     14'h0d00
`define IDX_MASK_ONE     14'h0d08
`define IDX_FLAG_TWO     14'h0d10
`define IDX_MASK_TWO     14'h0d18

// latched flag banks
`define NUM_SOURCES      6
`define NUM_GROUPS       2
`define SRC_BOOT         3

// used bits of the per-subsystem clock error words
`define OVER_A_USED      16'h37ff
`define OVER_B_USED      16'hffaf

// bits whose flag also latches on a falling edge
`define BOTH_DSP         16'h00ff
`define BOTH_CLOCK       16'hc78c
`define BOTH_CONTROL     16'h0000
`define BOTH_BOOT        16'h0003
`define BOTH_SHORT       16'h7000
`define BOTH_AOD         16'h000d

// reset values
`define MASK_RST         16'hffff
`define MASK_RST_BOOT    16'hfeff
`define CLK_CTRL_RST     2'h3
`define WORD_ZERO        16'h0000
`define DATA_ZERO        32'h0000_0000

// field positions
`define CTRL_MAIN        0
`define CTRL_SECOND      1
`define BIT_OVERCLOCK    5
`define BIT_UNDERCLOCK   6
`define BIT_SEQ_IDLE     11
`define BIT_MAIN_OFF     9
`define BIT_SECOND_OFF   10
`define BIT_BOOT_DONE    8
`define BIT_JACK         0

`endif

// ===== common/irq_bank_pkg.sv
// shared types of the raw status bank
package irq_bank_pkg;
	typedef logic [15:0] status_word_t;
	typedef logic [13:0] reg_index_t;
	typedef enum logic [1:0] {
		RESP_OKAY   = 2'h0,
		RESP_SLVERR = 2'h2
	} axi_resp_t;
endpackage : irq_bank_pkg

// ===== design/flag_bank.sv
// one word of edge-latched interrupt flags with write-one-to-clear
`include "irq_bank_params.svh"
module flag_bank (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	// status source and edge selection
	input  wire irq_bank_pkg::status_word_t raw,
	input  wire irq_bank_pkg::status_word_t bothEdges,
	// host clear, one bit per flag
	input  wire irq_bank_pkg::status_word_t clear,
	// latched flags
	output irq_bank_pkg::status_word_t      flags
);
	irq_bank_pkg::status_word_t prev;
	irq_bank_pkg::status_word_t set;

	assign set = (raw & ~prev) | (bothEdges & ~raw & prev);

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			prev <= `WORD_ZERO;
		end else begin
			prev <= raw;
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			flags <= `WORD_ZERO;
		end else begin
			flags <= (flags & ~clear) | set;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	flag_edge_set_a: assert property ((set != `WORD_ZERO) |=>
		((flags & $past(set)) == $past(set)))
		else $error("edge did not latch its flag");
	flag_clear_a: assert property (((clear & ~set & flags) != `WORD_ZERO) |=>
		((flags & $past(clear & ~set)) == `WORD_ZERO))
		else $error("write of one did not clear flag");
endmodule : flag_bank

// ===== design/interrupt_raw_status_bank.sv
// raw interrupt status bank with latched flags, masks and pin summaries
//
// Implementation choice: the AXI4-Lite register port.
`include "irq_bank_params.svh"
module interrupt_raw_status_bank (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   resetn,
	// register bus write address
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [15:0]            awaddr,
	// register bus write data
	input  wire logic                   wvalid,
	output logic                        wready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	// register bus write response
	output logic                        bvalid,
	input  wire logic                   bready,
	output irq_bank_pkg::axi_resp_t     bresp,
	// register bus read
	input  wire logic                   arvalid,
	output logic                        arready,
	input  wire logic [15:0]            araddr,
	output logic                        rvalid,
	input  wire logic                   rready,
	output logic [31:0]                 rdata,
	output irq_bank_pkg::axi_resp_t     rresp,
	// core and loop status
	input  wire logic [7:0]             coreEventFlag,
	input  wire logic [3:0]             coreMemoryReady,
	input  wire logic [1:0]             loopLocked,
	input  wire logic [1:0]             loopClockGood,
	input  wire logic [1:0]             asyncConverterLocked,
	input  wire logic                   mainClockTooSlow,
	input  wire logic                   secondClockTooSlow,
	// sequencers
	input  wire logic                   sequencerIdle,
	input  wire logic                   startupComplete,
	input  wire logic [5:0]             headphoneEnableDone,
	// speaker and headphone protection
	input  wire logic                   speakerThermalWarning,
	input  wire logic                   speakerThermalLimit,
	input  wire logic                   speakerShutdownDone,
	input  wire logic [1:0]             speakerShort,
	input  wire logic [11:0]            headphoneShort,
	// signal path errors
	input  wire logic [1:0]             compressorSignalSeen,
	input  wire logic                   hostPortError,
	input  wire logic                   mixerSampleLost,
	input  wire logic [2:0]             isoConverterConfigError,
	input  wire logic                   asyncConverterConfigError,
	input  wire logic                   converterOverflow,
	input  wire logic                   converterBufferError,
	// per-subsystem clock errors
	input  wire logic [15:0]            overclockA,
	input  wire logic [15:0]            overclockB,
	input  wire logic [10:0]            underclock,
	// always-on detect inputs
	input  wire logic                   jackSenseN,
	input  wire logic                   generalInputFive,
	input  wire logic                   micDetectClampActive,
	// clock control
	input  wire logic                   mainClockStopped,
	input  wire logic                   secondClockStopped,
	output logic                        mainClockEnable,
	output logic                        secondClockEnable,
	// interrupt pin summaries
	output logic                        pinOneSummary,
	output logic                        pinTwoSummary
);
	irq_bank_pkg::status_word_t rawDsp;
	irq_bank_pkg::status_word_t rawClock;
	irq_bank_pkg::status_word_t rawControl;
	irq_bank_pkg::status_word_t rawBoot;
	irq_bank_pkg::status_word_t rawOverA;
	irq_bank_pkg::status_word_t rawOverB;
	irq_bank_pkg::status_word_t rawUnder;
	irq_bank_pkg::status_word_t rawShort;
	irq_bank_pkg::status_word_t rawAod;
	irq_bank_pkg::status_word_t srcWord   [`NUM_SOURCES];
	irq_bank_pkg::status_word_t bothWord  [`NUM_SOURCES];
	irq_bank_pkg::status_word_t flagWord  [`NUM_GROUPS][`NUM_SOURCES];
	irq_bank_pkg::status_word_t maskWord  [`NUM_GROUPS][`NUM_SOURCES];
	irq_bank_pkg::status_word_t flagClear [`NUM_GROUPS][`NUM_SOURCES];
	irq_bank_pkg::status_word_t wrBits;
	irq_bank_pkg::reg_index_t   wrIdx;
	irq_bank_pkg::reg_index_t   rdIdx;
	logic [31:0]                wrData;
	logic [3:0]                 wrStrb;
	logic [31:0]                next_rdata;
	logic [1:0]                 clkCtrl;
	logic [1:0]                 pending;
	logic                       awHeld;
	logic                       wHeld;
	logic                       doWrite;
	logic                       anyOver;
	logic                       anyUnder;
	logic                       mainOff;
	logic                       secondOff;

	function automatic logic inBank(input irq_bank_pkg::reg_index_t idx,
		input irq_bank_pkg::reg_index_t base);
		return (idx >= base) && (idx < base + 14'(`NUM_SOURCES));
	endfunction : inBank

	function automatic logic mapped(input irq_bank_pkg::reg_index_t idx);
		logic hit;
		hit = 1'b0;
		if (idx >= `IDX_RAW_DSP && idx <= `IDX_RAW_UNDER) begin
			hit = 1'b1;
		end else if (idx == `IDX_RAW_SHORT || idx == `IDX_PIN_SUMMARY) begin
			hit = 1'b1;
		end else if (idx == `IDX_RAW_AOD || idx == `IDX_CLK_CTRL) begin
			hit = 1'b1;
		end else if (inBank(idx, `IDX_FLAG_ONE) || inBank(idx, `IDX_MASK_ONE)) begin
			hit = 1'b1;
		end else if (inBank(idx, `IDX_FLAG_TWO) || inBank(idx, `IDX_MASK_TWO)) begin
			hit = 1'b1;
		end
		return hit;
	endfunction : mapped

	// subsystem clock error summaries, unused bit positions never count
	assign anyOver   = |(overclockA & `OVER_A_USED) || |(overclockB & `OVER_B_USED);
	assign anyUnder  = |underclock;
	assign mainOff   = !clkCtrl[`CTRL_MAIN] && mainClockStopped;
	assign secondOff = !clkCtrl[`CTRL_SECOND] && secondClockStopped;
	assign mainClockEnable   = clkCtrl[`CTRL_MAIN];
	assign secondClockEnable = clkCtrl[`CTRL_SECOND];

	// live status words, refreshed every cycle; host writes never reach them
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rawDsp     <= `WORD_ZERO;
			rawClock   <= `WORD_ZERO;
			rawControl <= `WORD_ZERO;
			rawBoot    <= `WORD_ZERO;
			rawOverA   <= `WORD_ZERO;
			rawOverB   <= `WORD_ZERO;
			rawUnder   <= `WORD_ZERO;
			rawShort   <= `WORD_ZERO;
			rawAod     <= `WORD_ZERO;
		end else begin
			rawDsp     <= {4'h0, coreMemoryReady, coreEventFlag};
			rawClock   <= {speakerThermalWarning, speakerThermalLimit, 2'h0,
				sequencerIdle, compressorSignalSeen, asyncConverterLocked,
				anyUnder, anyOver, 1'h0, loopLocked,
				mainClockTooSlow, secondClockTooSlow};
			rawControl <= {3'h0, hostPortError, mixerSampleLost,
				secondOff, mainOff,
				isoConverterConfigError[0], isoConverterConfigError[1],
				isoConverterConfigError[2], headphoneEnableDone};
			rawBoot    <= {7'h00, startupComplete, 2'h0, converterOverflow,
				converterBufferError, asyncConverterConfigError,
				1'h0, loopClockGood};
			rawOverA   <= overclockA & `OVER_A_USED;
			rawOverB   <= overclockB & `OVER_B_USED;
			rawUnder   <= {5'h00, underclock};
			rawShort   <= {1'h0, speakerShutdownDone, speakerShort, headphoneShort};
			rawAod     <= {12'h000, micDetectClampActive, generalInputFive,
				1'h0, ~jackSenseN};
		end
	end

	assign srcWord[0]  = rawDsp;
	assign srcWord[1]  = rawClock;
	assign srcWord[2]  = rawControl;
	assign srcWord[3]  = rawBoot;
	assign srcWord[4]  = rawShort;
	assign srcWord[5]  = rawAod;
	assign bothWord[0] = `BOTH_DSP;
	assign bothWord[1] = `BOTH_CLOCK;
	assign bothWord[2] = `BOTH_CONTROL;
	assign bothWord[3] = `BOTH_BOOT;
	assign bothWord[4] = `BOTH_SHORT;
	assign bothWord[5] = `BOTH_AOD;

	// write channel capture, address and data in either order
	assign awready = !awHeld;
	assign wready  = !wHeld;
	assign doWrite = awHeld && wHeld && !bvalid;
	assign wrBits  = {{8{wrStrb[1]}}, {8{wrStrb[0]}}} & wrData[15:0];

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			awHeld <= 1'b0;
			wrIdx  <= `IDX_RAW_DSP;
		end else if (awvalid && awready) begin
			awHeld <= 1'b1;
			wrIdx  <= awaddr[15:2];
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			wHeld  <= 1'b0;
			wrData <= `DATA_ZERO;
			wrStrb <= 4'h0;
		end else if (wvalid && wready) begin
			wHeld  <= 1'b1;
			wrData <= wdata;
			wrStrb <= wstrb;
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end
	end

	// raw words accept a write silently; unmapped space answers an error
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			bvalid <= 1'b0;
			bresp  <= irq_bank_pkg::RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp  <= mapped(wrIdx) ? irq_bank_pkg::RESP_OKAY : irq_bank_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			clkCtrl <= `CLK_CTRL_RST;
		end else if (doWrite && wrIdx == `IDX_CLK_CTRL && wrStrb[0]) begin
			clkCtrl <= wrData[1:0];
		end
	end

	// flag and mask banks, one word per source and group
	for (genvar g = 0; g < `NUM_GROUPS; g++) begin : gen_group
		localparam irq_bank_pkg::reg_index_t FLAG_BASE = (g == 0) ? `IDX_FLAG_ONE : `IDX_FLAG_TWO;
		localparam irq_bank_pkg::reg_index_t MASK_BASE = (g == 0) ? `IDX_MASK_ONE : `IDX_MASK_TWO;
		for (genvar k = 0; k < `NUM_SOURCES; k++) begin : gen_src
			localparam irq_bank_pkg::status_word_t MASK_INIT =
				(k == `SRC_BOOT) ? `MASK_RST_BOOT : `MASK_RST;
			assign flagClear[g][k] = (doWrite && wrIdx == FLAG_BASE + 14'(k)) ?
				wrBits : `WORD_ZERO;

			always_ff @(posedge clk_sys) begin
				if (!resetn) begin
					maskWord[g][k] <= MASK_INIT;
				end else if (doWrite && wrIdx == MASK_BASE + 14'(k)) begin
					maskWord[g][k] <= (maskWord[g][k] & ~{{8{wrStrb[1]}}, {8{wrStrb[0]}}})
						| wrBits;
				end
			end

			flag_bank u_flags (
				.clk_sys   (clk_sys),
				.resetn    (resetn),
				.raw       (srcWord[k]),
				.bothEdges (bothWord[k]),
				.clear     (flagClear[g][k]),
				.flags     (flagWord[g][k])
			);
		end
	end

	// a flag drives its pin only while its mask bit is zero
	always_comb begin
		pending = 2'h0;
		for (int g = 0; g < `NUM_GROUPS; g++) begin
			for (int k = 0; k < `NUM_SOURCES; k++) begin
				pending[g] = pending[g] | (|(flagWord[g][k] & ~maskWord[g][k]));
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			pinOneSummary <= 1'b0;
			pinTwoSummary <= 1'b0;
		end else begin
			pinOneSummary <= pending[0];
			pinTwoSummary <= pending[1];
		end
	end

	// read decode
	assign arready = !rvalid;
	assign rdIdx   = araddr[15:2];

	always_comb begin
		next_rdata = `DATA_ZERO;
		if (rdIdx == `IDX_RAW_DSP) begin
			next_rdata = {16'h0000, rawDsp};
		end else if (rdIdx == `IDX_RAW_CLOCK) begin
			next_rdata = {16'h0000, rawClock};
		end else if (rdIdx == `IDX_RAW_CONTROL) begin
			next_rdata = {16'h0000, rawControl};
		end else if (rdIdx == `IDX_RAW_BOOT) begin
			next_rdata = {16'h0000, rawBoot};
		end else if (rdIdx == `IDX_RAW_OVER_A) begin
			next_rdata = {16'h0000, rawOverA};
		end else if (rdIdx == `IDX_RAW_OVER_B) begin
			next_rdata = {16'h0000, rawOverB};
		end else if (rdIdx == `IDX_RAW_UNDER) begin
			next_rdata = {16'h0000, rawUnder};
		end else if (rdIdx == `IDX_RAW_SHORT) begin
			next_rdata = {16'h0000, rawShort};
		end else if (rdIdx == `IDX_PIN_SUMMARY) begin
			next_rdata = {30'h0, pinTwoSummary, pinOneSummary};
		end else if (rdIdx == `IDX_RAW_AOD) begin
			next_rdata = {16'h0000, rawAod};
		end else if (rdIdx == `IDX_CLK_CTRL) begin
			next_rdata = {30'h0, clkCtrl};
		end else begin
			for (int k = 0; k < `NUM_SOURCES; k++) begin
				if (rdIdx == `IDX_FLAG_ONE + 14'(k)) begin
					next_rdata = {16'h0000, flagWord[0][k]};
				end else if (rdIdx == `IDX_MASK_ONE + 14'(k)) begin
					next_rdata = {16'h0000, maskWord[0][k]};
				end else if (rdIdx == `IDX_FLAG_TWO + 14'(k)) begin
					next_rdata = {16'h0000, flagWord[1][k]};
				end else if (rdIdx == `IDX_MASK_TWO + 14'(k)) begin
					next_rdata = {16'h0000, maskWord[1][k]};
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rvalid <= 1'b0;
			rdata  <= `DATA_ZERO;
			rresp  <= irq_bank_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= next_rdata;
			rresp  <= mapped(rdIdx) ? irq_bank_pkg::RESP_OKAY : irq_bank_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	pin_falls_write_a: assert property ($fell(pinOneSummary) || $fell(pinTwoSummary)
		|-> $past(doWrite, 2))
		else $error("pin summary dropped without a host write");
	overclock_sum_a: assert property (anyOver |=> rawClock[`BIT_OVERCLOCK])
		else $error("combined overclock missed a subsystem bit");
	underclock_sum_a: assert property (rawClock[`BIT_UNDERCLOCK] |-> $past(|underclock))
		else $error("combined underclock set without cause");
	main_clk_off_a: assert property ((clkCtrl[`CTRL_MAIN] || !mainClockStopped)
		|=> !rawControl[`BIT_MAIN_OFF])
		else $error("main clock disabled shown too early");
	second_clk_off_a: assert property ((!clkCtrl[`CTRL_SECOND] && secondClockStopped)
		##1 (!clkCtrl[`CTRL_SECOND] && secondClockStopped) |-> rawControl[`BIT_SECOND_OFF])
		else $error("second clock disabled not shown");
	boot_status_a: assert property (!startupComplete |=> !rawBoot[`BIT_BOOT_DONE])
		else $error("boot status high during boot");
	seq_idle_a: assert property (rawClock[`BIT_SEQ_IDLE] == $past(sequencerIdle))
		else $error("sequencer idle bit not tracking");
	jack_present_a: assert property (rawAod[`BIT_JACK] == !$past(jackSenseN))
		else $error("jack presence polarity wrong");
	unused_zero_a: assert property ((rawShort[15] == 1'b0) && (rawAod[15:4] == 12'h000)
		&& (rawBoot[7:6] == 2'h0) && (rawClock[13:12] == 2'h0))
		else $error("unassigned status bit reads one");
	unmapped_read_a: assert property ((arvalid && arready && !mapped(rdIdx))
		|=> rvalid && rresp == irq_bank_pkg::RESP_SLVERR && rdata == `DATA_ZERO)
		else $error("unmapped read not refused");

	pin_two_rise_c: cover property ($rose(pinTwoSummary));
	main_clk_stop_c: cover property ($rose(rawControl[`BIT_MAIN_OFF]));
	flag_read_c: cover property (arvalid && arready && inBank(rdIdx, `IDX_FLAG_TWO));
	write_resp_c: cover property (bvalid && bready);
endmodule : interrupt_raw_status_bank

// ===== dv/host_master.sv
// bus master model of the host that polls the status bank
module host_master (
	// clock
	input  wire logic                    clk_sys,
	// write channels
	output logic                         awvalid,
	input  wire logic                    awready,
	output logic [15:0]                  awaddr,
	output logic                         wvalid,
	input  wire logic                    wready,
	output logic [31:0]                  wdata,
	output logic [3:0]                   wstrb,
	input  wire logic                    bvalid,
	output logic                         bready,
	input  wire irq_bank_pkg::axi_resp_t bresp,
	// read channels
	output logic                         arvalid,
	input  wire logic                    arready,
	output logic [15:0]                  araddr,
	input  wire logic                    rvalid,
	output logic                         rready,
	input  wire logic [31:0]             rdata,
	input  wire irq_bank_pkg::axi_resp_t rresp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
	end
	// ready is sampled at the negedge, equal to its value at the next edge
	task automatic wr(input logic [13:0] idx, input logic [31:0] d,
			output irq_bank_pkg::axi_resp_t r);
		logic aw;
		logic w;
		logic ta;
		logic tw;
		logic tk;
		@(posedge clk_sys);
		awaddr <= {idx, 2'b00};
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(negedge clk_sys);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge clk_sys);
			if (ta) begin
				awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				w = 1'b0;
			end
		end
		bready <= 1'b1;
		do begin
			@(negedge clk_sys);
			tk = bvalid;
			r = bresp;
			@(posedge clk_sys);
		end while (!tk);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [13:0] idx, output logic [31:0] d,
			output irq_bank_pkg::axi_resp_t r);
		logic tk;
		@(posedge clk_sys);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		do begin
			@(negedge clk_sys);
			tk = arready;
			@(posedge clk_sys);
		end while (!tk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(negedge clk_sys);
			tk = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
		end while (!tk);
		rready <= 1'b0;
	endtask : rd
endmodule : host_master

// ===== dv/tb_interrupt_raw_status_bank.sv
// self-checking bench of the raw status bank
`include "irq_bank_params.svh"
module tb_interrupt_raw_status_bank;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [15:0] awaddr, araddr, overclockA, overclockB;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, coreMemoryReady;
	irq_bank_pkg::axi_resp_t bresp, rresp;
	logic [7:0] coreEventFlag;
	logic [1:0] loopLocked, loopClockGood, asyncConverterLocked, speakerShort, compressorSignalSeen;
	logic mainClockTooSlow, secondClockTooSlow, sequencerIdle, hostPortError;
	logic startupComplete = 1'b0;
	logic speakerThermalWarning, speakerThermalLimit, speakerShutdownDone, mixerSampleLost;
	logic asyncConverterConfigError, converterOverflow, converterBufferError, jackSenseN;
	logic generalInputFive, micDetectClampActive, mainClockStopped, secondClockStopped;
	logic mainClockEnable, secondClockEnable, pinOneSummary, pinTwoSummary;
	logic [5:0] headphoneEnableDone;
	logic [11:0] headphoneShort;
	logic [2:0] isoConverterConfigError;
	logic [10:0] underclock;
	int errTotal = 0;
	int comparisons = 0;
	interrupt_raw_status_bank dut_u (
		.clk_sys, .resetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.coreEventFlag, .coreMemoryReady, .loopLocked, .loopClockGood, .asyncConverterLocked,
		.mainClockTooSlow, .secondClockTooSlow, .sequencerIdle, .startupComplete,
		.headphoneEnableDone, .speakerThermalWarning, .speakerThermalLimit, .speakerShutdownDone,
		.speakerShort, .headphoneShort, .compressorSignalSeen, .hostPortError, .mixerSampleLost,
		.isoConverterConfigError, .asyncConverterConfigError, .converterOverflow,
		.converterBufferError, .overclockA, .overclockB, .underclock, .jackSenseN,
		.generalInputFive, .micDetectClampActive, .mainClockStopped, .secondClockStopped,
		.mainClockEnable, .secondClockEnable, .pinOneSummary, .pinTwoSummary
	);
	host_master host_u (
		.clk_sys, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
		.bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp
	);
	always #5 clk_sys = ~clk_sys;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rdchk(input string what, input logic [13:0] idx, input logic [31:0] exp,
			input irq_bank_pkg::axi_resp_t er);
		logic [31:0] d;
		irq_bank_pkg::axi_resp_t r;
		host_u.rd(idx, d, r);
		chk(what, exp, d);
		chk({what, " resp"}, 32'(er), 32'(r));
	endtask : rdchk
	task automatic wrchk(input logic [13:0] idx, input logic [31:0] d,
			input irq_bank_pkg::axi_resp_t er);
		irq_bank_pkg::axi_resp_t r;
		host_u.wr(idx, d, r);
		chk("write resp", 32'(er), 32'(r));
	endtask : wrchk
	// pins are registered levels, looked at mid-cycle
	task automatic pins(input logic one, input logic two);
		@(negedge clk_sys);
		chk("pin one", 32'(one), 32'(pinOneSummary));
		chk("pin two", 32'(two), 32'(pinTwoSummary));
	endtask : pins
	task automatic zero_in();
		{coreEventFlag, coreMemoryReady, loopLocked, loopClockGood, asyncConverterLocked} <= '0;
		{mainClockTooSlow, secondClockTooSlow, sequencerIdle} <= '0;
		{headphoneEnableDone, speakerThermalWarning, speakerThermalLimit} <= '0;
		{speakerShutdownDone, speakerShort, headphoneShort, compressorSignalSeen} <= '0;
		{hostPortError, mixerSampleLost, isoConverterConfigError, asyncConverterConfigError} <= '0;
		{converterOverflow, converterBufferError, overclockA, overclockB, underclock} <= '0;
		{generalInputFive, micDetectClampActive, mainClockStopped, secondClockStopped} <= '0;
		jackSenseN <= 1'b1;
	endtask : zero_in
	task automatic t_reset();
		rdchk("clock ctrl", `IDX_CLK_CTRL, 32'h0000_0003, irq_bank_pkg::RESP_OKAY);
		rdchk("summary", `IDX_PIN_SUMMARY, 32'h0000_0000, irq_bank_pkg::RESP_OKAY);
		rdchk("mask boot", `IDX_MASK_ONE + 14'd3, 32'h0000_feff, irq_bank_pkg::RESP_OKAY);
		rdchk("mask dsp", `IDX_MASK_TWO, 32'h0000_ffff, irq_bank_pkg::RESP_OKAY);
		rdchk("aod", `IDX_RAW_AOD, 32'h0000_0000, irq_bank_pkg::RESP_OKAY);
		rdchk("unmapped", 14'h0d30, 32'h0000_0000, irq_bank_pkg::RESP_SLVERR);
		wrchk(14'h0d30, 32'h0000_ffff, irq_bank_pkg::RESP_SLVERR);
	endtask : t_reset
	task automatic t_map();
		@(posedge clk_sys);
		{coreEventFlag, coreMemoryReady, loopLocked, loopClockGood} <= 16'ha596;
		{asyncConverterLocked, compressorSignalSeen, speakerShort} <= 6'b10_10_10;
		{mainClockTooSlow, secondClockTooSlow, sequencerIdle} <= 3'b111;
		{speakerThermalWarning, speakerThermalLimit, speakerShutdownDone} <= 3'b111;
		{hostPortError, mixerSampleLost, isoConverterConfigError} <= 5'b11_001;
		{asyncConverterConfigError, converterOverflow, converterBufferError} <= 3'b111;
		headphoneEnableDone <= 6'h21;
		headphoneShort <= 12'h801;
		{jackSenseN, generalInputFive, micDetectClampActive} <= 3'b011;
		rdchk("dsp", `IDX_RAW_DSP, 32'h0000_09a5, irq_bank_pkg::RESP_OKAY);
		rdchk("clock", `IDX_RAW_CLOCK, 32'h0000_cd07, irq_bank_pkg::RESP_OKAY);
		rdchk("control", `IDX_RAW_CONTROL, 32'h0000_1921, irq_bank_pkg::RESP_OKAY);
		rdchk("boot", `IDX_RAW_BOOT, 32'h0000_013a, irq_bank_pkg::RESP_OKAY);
		rdchk("short", `IDX_RAW_SHORT, 32'h0000_6801, irq_bank_pkg::RESP_OKAY);
		rdchk("aod", `IDX_RAW_AOD, 32'h0000_000d, irq_bank_pkg::RESP_OKAY);
		wrchk(`IDX_RAW_CLOCK, 32'h0000_0000, irq_bank_pkg::RESP_OKAY);
		rdchk("clock kept", `IDX_RAW_CLOCK, 32'h0000_cd07, irq_bank_pkg::RESP_OKAY);
		@(posedge clk_sys);
		zero_in();
	endtask : t_map
	task automatic t_comb();
		logic [15:0] oa [4] = '{16'h2000, 16'h0000, 16'h0000, 16'h4000};
		logic [15:0] ob [4] = '{16'h0000, 16'h0008, 16'h0000, 16'h0000};
		logic [10:0] uc [4] = '{11'h000, 11'h000, 11'h400, 11'h000};
		logic [31:0] ex [4] = '{32'h0000_0020, 32'h0000_0020, 32'h0000_0040, 32'h0000_0000};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			overclockA <= oa[i];
			overclockB <= ob[i];
			underclock <= uc[i];
			rdchk("combined", `IDX_RAW_CLOCK, ex[i], irq_bank_pkg::RESP_OKAY);
		end
		rdchk("over a", `IDX_RAW_OVER_A, 32'h0000_0000, irq_bank_pkg::RESP_OKAY);
		@(posedge clk_sys);
		overclockB <= 16'hffff;
		rdchk("over b", `IDX_RAW_OVER_B, 32'h0000_ffaf, irq_bank_pkg::RESP_OKAY);
	endtask : t_comb
	// boot bit is the only one unmasked out of reset
	task automatic t_boot();
		@(posedge clk_sys);
		zero_in();
		@(posedge clk_sys);
		startupComplete <= 1'b1;
		rdchk("boot", `IDX_RAW_BOOT, 32'h0000_0100, irq_bank_pkg::RESP_OKAY);
		pins(1'b1, 1'b1);
		rdchk("summary", `IDX_PIN_SUMMARY, 32'h0000_0003, irq_bank_pkg::RESP_OKAY);
		wrchk(`IDX_FLAG_ONE + 14'd3, 32'h0000_0100, irq_bank_pkg::RESP_OKAY);
		pins(1'b0, 1'b1);
		rdchk("flag two", `IDX_FLAG_TWO + 14'd3, 32'h0000_0100, irq_bank_pkg::RESP_OKAY);
		wrchk(`IDX_MASK_TWO + 14'd3, 32'h0000_ffff, irq_bank_pkg::RESP_OKAY);
		pins(1'b0, 1'b0);
		rdchk("summary", `IDX_PIN_SUMMARY, 32'h0000_0000, irq_bank_pkg::RESP_OKAY);
	endtask : t_boot
	// host reads the disabled flags once, a cycle after the stops rise, and expects 1
	task automatic t_clk();
		wrchk(`IDX_CLK_CTRL, 32'h0000_0000, irq_bank_pkg::RESP_OKAY);
		pins(1'b0, 1'b0);
		chk("enables", 32'h0000_0000, {30'h0, secondClockEnable, mainClockEnable});
		rdchk("control", `IDX_RAW_CONTROL, 32'h0000_0000, irq_bank_pkg::RESP_OKAY);
		@(posedge clk_sys);
		{mainClockStopped, secondClockStopped} <= 2'b11;
		@(posedge clk_sys);
		rdchk("control", `IDX_RAW_CONTROL, 32'h0000_0600, irq_bank_pkg::RESP_OKAY);
		wrchk(`IDX_CLK_CTRL, 32'h0000_0003, irq_bank_pkg::RESP_OKAY);
		rdchk("control", `IDX_RAW_CONTROL, 32'h0000_0000, irq_bank_pkg::RESP_OKAY);
	endtask : t_clk
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	initial begin
		zero_in();
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		// boot first: the host writes nothing before boot completes
		t_boot();
		t_reset();
		t_map();
		t_comb();
		t_clk();
		wrap_up();
	end
	// whole run is well under a thousand cycles, so this only trips on a hang
	initial begin
		#200us;
		errTotal++;
		wrap_up();
	end
endmodule : tb_interrupt_raw_status_bank
